//--- rtl/mc_error_log_map.svh
// register map, field positions and codes for the memory controller error log
`ifndef MC_ERROR_LOG_MAP_SVH
`define MC_ERROR_LOG_MAP_SVH

`define FIRST_BANK_LO 8'h09
`define FIRST_BANK_HI 8'h0C
`define SECOND_BANK_LO 8'h0D
`define SECOND_BANK_HI 8'h10
`define NUM_BANKS 8

`define CTRL_EXTRA_LOG_BIT 1

`define ST_CODE_LO 0
`define ST_CODE_HI 15
`define ST_MS_LO 16
`define ST_MS_HI 31
`define ST_DEV_LO 32
`define ST_DEV_HI 36
`define ST_ARCH_LO 38

`define MI_ADDR_HI 8
`define MI_ID_LO 9
`define MI_ID_HI 13
`define MI_MASK1_LO 14
`define MI_MASK1_HI 29
`define MI_MASK2_LO 30
`define MI_MASK2_HI 45
`define MI_RANK1_LO 46
`define MI_RANK1_HI 50
`define MI_RANK2_LO 51
`define MI_RANK2_HI 55
`define MI_VALID1 62
`define MI_VALID2 63

`define CODE_MASK 16'hF0FF
`define CODE_FORM_BIT 7

`define MS_ADDR_PAR 16'h0001
`define MS_WR_DATA_PAR 16'h0002
`define MS_WR_BE_PAR 16'h0004
`define MS_SCRUB_CORR 16'h0008
`define MS_SCRUB_UNCORR 16'h0010
`define MS_SPARE_CORR 16'h0020
`define MS_SPARE_UNCORR 16'h0040
`define MS_READ_CORR 16'h0080
`define MS_WDB_PAR 16'h0100
`define MS_NONE 16'h0000

`endif

//--- rtl/mc_error_log_pkg.sv
// types for the memory controller error log
package mc_error_log_pkg;
  typedef enum logic [3:0] {
    ERR_ADDR_PAR = 4'h0,
    ERR_WR_DATA_PAR = 4'h1,
    ERR_WR_BE_PAR = 4'h2,
    ERR_SCRUB_CORR = 4'h3,
    ERR_SCRUB_UNCORR = 4'h4,
    ERR_SPARE_CORR = 4'h5,
    ERR_SPARE_UNCORR = 4'h6,
    ERR_READ_CORR = 4'h7,
    ERR_WDB_PAR = 4'h8
  } err_kind_e;

  typedef struct packed {
    logic [63:0] ctrl;
    logic [7:0][63:0] status;
    logic [7:0][63:0] misc;
    logic [63:0] rdata;
  } log_state_s;
endpackage : mc_error_log_pkg

//--- rtl/memory_controller_error_log.sv
// error logging banks of the two integrated memory controllers
`timescale 1ns/1ps
`include "mc_error_log_map.svh"

// Operation
// R1 - first controller logs to banks 9-12
// R2 - second controller logs to banks 13-16
// R3 - low sixteen bits hold architectural code
// R4 - codes 001H, 002H, 004H for parity errors
// R5 - patrol scrub codes 008H and 010H
// R6 - spare codes 020H and 040H
// R7 - read corrected code 080H only extended
// R8 - write buffer parity code 100H
// R9 - control bit 1 enables extra logging
// R10 - status 36:32 first failing device
// R11 - misc 13:9 buffer id or device
// R12 - misc 29:14 first device mask
// R13 - misc 45:30 second device mask
// R14 - misc 50:46 first device rank
// R15 - misc 55:51 second device rank
// R16 - bit 62 first device valid
// R17 - bit 63 second device valid
// R18 - reader trusts second only with first
// R19 - flags stay clear when extra off
module memory_controller_error_log
  import mc_error_log_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // error report from either controller
  input wire logic err_valid,
  input wire logic err_ctrl_sel,
  input wire logic [1:0] err_channel,
  input wire err_kind_e err_kind,
  input wire logic [15:0] err_arch_code,
  input wire logic [4:0] err_device,
  input wire logic [15:0] err_bit_mask,
  input wire logic [4:0] err_rank,
  input wire logic [4:0] err_buffer_id,
  input wire logic [8:0] err_addr_info,
  input wire logic [24:0] err_arch_upper,
  // model-specific register access
  input wire logic msr_rd,
  input wire logic msr_wr,
  input wire logic [7:0] msr_index,
  input wire logic msr_sel_misc,
  input wire logic msr_sel_ctrl,
  input wire logic [63:0] msr_wdata,
  output logic [63:0] msr_rdata,
  output logic extra_logging_on
);

  // ----------------------------------------------------------------
  // bank decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] bank_of_index(input logic [7:0] idx);
    logic [7:0] off;
    off = 8'h00;
    if (idx >= `FIRST_BANK_LO && idx <= `SECOND_BANK_HI) begin
      off = idx - `FIRST_BANK_LO;
      bank_of_index = {1'b0, off[2:0]};
    end else begin
      bank_of_index = 4'h8;
    end
  endfunction : bank_of_index

  function automatic logic [15:0] ms_code(input err_kind_e k);
    unique case (k)
      ERR_ADDR_PAR: ms_code = `MS_ADDR_PAR; // [R4]
      ERR_WR_DATA_PAR: ms_code = `MS_WR_DATA_PAR; // [R4]
      ERR_WR_BE_PAR: ms_code = `MS_WR_BE_PAR; // [R4]
      ERR_SCRUB_CORR: ms_code = `MS_SCRUB_CORR; // [R5]
      ERR_SCRUB_UNCORR: ms_code = `MS_SCRUB_UNCORR; // [R5]
      ERR_SPARE_CORR: ms_code = `MS_SPARE_CORR; // [R6]
      ERR_SPARE_UNCORR: ms_code = `MS_SPARE_UNCORR; // [R6]
      ERR_READ_CORR: ms_code = `MS_READ_CORR; // [R7]
      ERR_WDB_PAR: ms_code = `MS_WDB_PAR; // [R8]
      default: ms_code = `MS_NONE;
    endcase
  endfunction : ms_code

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  log_state_s state_reg;
  log_state_s state_next;

  logic [2:0] err_bank;
  logic extra_on;
  logic [15:0] arch_error_code;
  logic [3:0] rd_bank;
  logic [3:0] wr_bank;

  // controller 0 -> banks 9-12, controller 1 -> 13-16
  assign err_bank = {err_ctrl_sel, err_channel}; // [R1] [R2]
  assign extra_on = state_reg.ctrl[`CTRL_EXTRA_LOG_BIT]; // [R9]
  // keep bits 15:12 and 7:0, force bit 7 for form 1MMMCCCC
  assign arch_error_code = (err_arch_code & `CODE_MASK)
    | (16'h0001 << `CODE_FORM_BIT); // [R3]
  assign rd_bank = bank_of_index(msr_index);
  assign wr_bank = bank_of_index(msr_index);

  always_comb begin
    logic [63:0] st;
    logic [63:0] mi;
    logic read_corr;
    logic log_it;
    st = 64'h0;
    mi = 64'h0;
    state_next = state_reg;
    read_corr = (err_kind == ERR_READ_CORR);
    // corrected read reported only in extended mode
    log_it = err_valid && (!read_corr || extra_on); // [R7]

    // ----------------------------------------------------------------
    // software writes
    // ----------------------------------------------------------------
    if (msr_wr) begin
      if (msr_sel_ctrl) begin
        state_next.ctrl = msr_wdata; // [R9]
      end else if (!wr_bank[3]) begin
        if (msr_sel_misc) begin
          state_next.misc[wr_bank[2:0]] = msr_wdata;
        end else begin
          state_next.status[wr_bank[2:0]] = msr_wdata;
        end
      end
    end

    // ----------------------------------------------------------------
    // hardware capture, its fields overwrite a same-cycle write to the bank, other written bits stay
    // ----------------------------------------------------------------
    if (log_it) begin
      st = state_next.status[err_bank];
      mi = state_next.misc[err_bank];
      st[`ST_CODE_HI:`ST_CODE_LO] = arch_error_code; // [R3]
      st[`ST_MS_HI:`ST_MS_LO] = ms_code(err_kind);
      st[63:`ST_ARCH_LO] = {err_arch_upper, 1'b0};
      mi[`MI_ADDR_HI:0] = err_addr_info;
      if (err_kind == ERR_WR_DATA_PAR || err_kind == ERR_WR_BE_PAR) begin
        mi[`MI_ID_HI:`MI_ID_LO] = err_buffer_id; // [R11]
      end
      if (extra_on) begin
        if (read_corr && mi[`MI_VALID1]) begin
          // second correctable device error
          mi[`MI_ID_HI:`MI_ID_LO] = err_device; // [R11]
          mi[`MI_MASK2_HI:`MI_MASK2_LO] = err_bit_mask; // [R13]
          mi[`MI_RANK2_HI:`MI_RANK2_LO] = err_rank; // [R15]
          mi[`MI_VALID2] = 1'b1; // [R17]
        end else begin
          st[`ST_DEV_HI:`ST_DEV_LO] = err_device; // [R10]
          mi[`MI_MASK1_HI:`MI_MASK1_LO] = err_bit_mask; // [R12]
          mi[`MI_RANK1_HI:`MI_RANK1_LO] = err_rank; // [R14]
          if (read_corr) begin
            mi[`MI_VALID1] = 1'b1; // [R16]
          end
        end
      end else begin
        mi[`MI_VALID1] = 1'b0; // [R19]
        mi[`MI_VALID2] = 1'b0; // [R19]
      end
      state_next.status[err_bank] = st;
      state_next.misc[err_bank] = mi;
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    state_next.rdata = state_reg.rdata;
    if (msr_rd) begin
      if (msr_sel_ctrl) begin
        state_next.rdata = state_reg.ctrl;
      end else if (rd_bank[3]) begin
        state_next.rdata = 64'h0;
      end else if (msr_sel_misc) begin
        state_next.rdata = state_reg.misc[rd_bank[2:0]];
      end else begin
        state_next.rdata = state_reg.status[rd_bank[2:0]];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign msr_rdata = state_reg.rdata;
  assign extra_logging_on = extra_on;

endmodule : memory_controller_error_log

//--- verification/mc_error_log_properties.sv
// checker for the memory controller error log
`timescale 1ns/1ps
module mc_error_log_checker
  import mc_error_log_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic err_valid,
  input wire logic err_ctrl_sel,
  input wire logic [1:0] err_channel,
  input wire err_kind_e err_kind,
  input wire logic [15:0] err_arch_code,
  input wire logic [4:0] err_device,
  input wire logic [4:0] err_buffer_id,
  input wire logic msr_rd,
  input wire logic msr_wr,
  input wire logic [7:0] msr_index,
  input wire logic msr_sel_misc,
  input wire logic msr_sel_ctrl,
  input wire logic [63:0] msr_wdata,
  input wire logic [63:0] msr_rdata,
  input wire logic extra_logging_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // capture, idle cycle, then read of the same bank
  sequence cap_rd(bit m);
    err_valid && !(err_kind == ERR_READ_CORR && !extra_logging_on)
    ##1 !err_valid ##1 msr_rd && !msr_wr && !err_valid && !msr_sel_ctrl
    && msr_sel_misc == m
    && msr_index == 8'h09 + {5'h00, $past(err_ctrl_sel, 2),
    $past(err_channel, 2)};
  endsequence
  a_ctrl_bit: assert property (msr_wr && msr_sel_ctrl |=>
    extra_logging_on == $past(msr_wdata[1])) else $error("bad enable");
  a_unmapped_zero: assert property (msr_rd && !msr_sel_ctrl &&
    (msr_index < 8'h09 || msr_index > 8'h10) |=> msr_rdata == 64'h0)
    else $error("unmapped read not zero");
  a_arch_code: assert property (cap_rd(0) |=> msr_rdata[15:0] ==
    (($past(err_arch_code, 3) & 16'hF0FF) | 16'h0080))
    else $error("bad architectural code");
  a_ms_code: assert property (cap_rd(0) |=>
    msr_rdata[31:16] == 16'h0001 << $past(err_kind, 3))
    else $error("bad model code");
  a_dev_field: assert property (extra_logging_on &&
    err_kind != ERR_READ_CORR ##0 cap_rd(0) |=>
    msr_rdata[36:32] == $past(err_device, 3)) else $error("bad device");
  a_wdb_id: assert property ((err_kind == ERR_WR_DATA_PAR ||
    err_kind == ERR_WR_BE_PAR) ##0 cap_rd(1) |=>
    msr_rdata[13:9] == $past(err_buffer_id, 3)) else $error("bad id");
  a_first_valid: assert property (extra_logging_on &&
    err_kind == ERR_READ_CORR ##0 cap_rd(1) |=> msr_rdata[62])
    else $error("first valid flag clear");
  a_flags_clear: assert property (!extra_logging_on ##0 cap_rd(1)
    |=> msr_rdata[63:62] == 2'b00) else $error("valid flags set");
  cover property (cap_rd(1));
  cover property (msr_wr && msr_sel_ctrl);
  cover property (extra_logging_on && err_valid && err_kind == ERR_READ_CORR);
endmodule : mc_error_log_checker

bind memory_controller_error_log mc_error_log_checker mc_error_log_checker_i (
  .clk, .rst, .err_valid, .err_ctrl_sel, .err_channel, .err_kind,
  .err_arch_code, .err_device, .err_buffer_id, .msr_rd, .msr_wr, .msr_index,
  .msr_sel_misc, .msr_sel_ctrl, .msr_wdata, .msr_rdata, .extra_logging_on);

//--- verification/memory_controller_error_log_tb.sv
// self-checking bench for the memory controller error log
`timescale 1ns/1ps
module memory_controller_error_log_tb
  import mc_error_log_pkg::*;
;
  logic clk = 0, rst = 1, err_valid = 0, err_ctrl_sel = 0, msr_rd = 0;
  logic msr_wr = 0, msr_sel_misc = 0, msr_sel_ctrl = 0, extra_logging_on;
  logic [1:0] err_channel = '0;
  err_kind_e err_kind = ERR_ADDR_PAR;
  logic [15:0] err_arch_code = '0, err_bit_mask = '0;
  logic [4:0] err_device = '0, err_rank = '0, err_buffer_id = '0;
  logic [8:0] err_addr_info = '0;
  logic [24:0] err_arch_upper = '0;
  logic [7:0] msr_index = '0;
  logic [63:0] msr_wdata = '0, msr_rdata, got;
  int failures = 0, samples_checked = 0;
  memory_controller_error_log memory_controller_error_log_i (.clk, .rst,
    .err_valid, .err_ctrl_sel, .err_channel, .err_kind, .err_arch_code,
    .err_device, .err_bit_mask, .err_rank, .err_buffer_id, .err_addr_info,
    .err_arch_upper, .msr_rd, .msr_wr, .msr_index, .msr_sel_misc,
    .msr_sel_ctrl, .msr_wdata, .msr_rdata, .extra_logging_on);
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(logic [63:0] g, e, m);
    samples_checked++;
    if ((g & m) !== (e & m)) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g & m, e & m);
    end
  endtask : chk
  task automatic msr(logic w, c, s, logic [7:0] i, logic [63:0] d);
    @(posedge clk);
    msr_wr <= w;
    msr_rd <= !w;
    msr_sel_ctrl <= c;
    msr_sel_misc <= s;
    msr_index <= i;
    msr_wdata <= d;
    @(posedge clk);
    msr_wr <= 0;
    msr_rd <= 0;
    #1 got = msr_rdata;
  endtask : msr
  task automatic err(logic [2:0] b, err_kind_e k, logic [4:0] v);
    @(posedge clk);
    err_valid <= 1;
    {err_ctrl_sel, err_channel} <= b;
    err_kind <= k;
    err_device <= v;
    err_buffer_id <= v + 5'h07;
    err_rank <= v + 5'h01;
    err_bit_mask <= {4{v[3:0]}} ^ 16'h5A5A;
    err_arch_code <= {v, 11'h7F3};
    err_addr_info <= {v, 4'h9};
    @(posedge clk);
    err_valid <= 0;
  endtask : err
  function automatic logic [63:0] st(logic [4:0] v, logic [15:0] ms);
    return {27'h0, v, ms, ({v, 11'h7F3} & 16'hF0FF) | 16'h0080};
  endfunction : st
  task automatic t_misc;
    msr(1, 1, 0, 8'h00, 64'h2);
    msr(0, 1, 0, 8'h00, 64'h0);
    chk(got, 64'h2, '1);
    err(3'h0, ERR_READ_CORR, 5'h03);
    msr(0, 0, 1, 8'h09, 64'h0);
    chk(got, {2'b01, 11'h0, 5'h04, 16'h0, 16'h6969, 14'h0039},
      64'hC007_C000_3FFF_C1FF);
    err(3'h0, ERR_READ_CORR, 5'h06);
    msr(0, 0, 1, 8'h09, 64'h0);
    chk(got, {2'b11, 6'h0, 5'h07, 5'h04, 16'h3C3C, 16'h6969, 14'h0C00},
      64'hC0FF_FFFF_FFFF_FE00);
    msr(0, 0, 0, 8'h09, 64'h0);
    // second device leaves the first device code 03 in 36:32
    chk(got, st(5'h06, 16'h0080) ^ 64'h0000_0005_0000_0000, '1);
    $display("extended logging test done");
  endtask : t_misc
  task automatic t_off;
    msr(1, 1, 0, 8'h00, 64'h0);
    err(3'h5, ERR_READ_CORR, 5'h02);
    msr(0, 0, 0, 8'h0E, 64'h0);
    chk(got, 64'h0, '1);
    err(3'h5, ERR_WR_DATA_PAR, 5'h08);
    msr(0, 0, 1, 8'h0E, 64'h0);
    chk(got, {50'h0, 5'h0F, 9'h0}, 64'hC000_0000_0000_3E00);
    msr(0, 0, 0, 8'h0E, 64'h0);
    chk(got, st(5'h08, 16'h0002), 64'hFFFF_FFE0_FFFF_FFFF);
    $display("plain logging test done");
  endtask : t_off
  task automatic t_codes;
    msr(1, 1, 0, 8'h00, 64'h2);
    for (int k = 0; k < 9; k++) begin
      err(k[2:0], err_kind_e'(k), k[4:0]);
      msr(0, 0, 0, {5'h00, k[2:0]} + 8'h09, 64'h0);
      chk(got, st(k[4:0], 16'h0001 << k), '1);
    end
    $display("error code test done");
  endtask : t_codes
  task automatic t_unmapped;
    msr(1, 0, 0, 8'h11, '1);
    msr(0, 0, 0, 8'h11, 64'h0);
    chk(got, 64'h0, '1);
    msr(0, 0, 1, 8'h08, 64'h0);
    chk(got, 64'h0, '1);
    $display("unmapped index test done");
  endtask : t_unmapped
  task automatic complete_run;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    t_misc;
    t_off;
    t_codes;
    t_unmapped;
    complete_run;
  end
  initial begin
    #20000;
    failures++;
    complete_run;
  end
endmodule : memory_controller_error_log_tb
